//--- design/mrf_pkg.sv
// Shared constants and types of the modem failover controller
package mrf_pkg;
	// ----------------------------------------------------------------
	// Sizes and timing
	// ----------------------------------------------------------------
	localparam int SLOTS = 10;
	localparam int SLOT_W = 4;
	localparam int HOLD_W = 7;
	localparam logic [HOLD_W-1:0] HOLD_MIN = 7'h01;
	localparam logic [HOLD_W-1:0] HOLD_MAX = 7'h63;
	localparam logic [HOLD_W-1:0] HOLD_RST = 7'h0a;
	localparam int CLK_FREQ_HZ = 10_000_000;
	localparam int TICK_PERIOD_S = 1;
	localparam int TICK_CYCLES = CLK_FREQ_HZ * TICK_PERIOD_S;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_ACTIVE = 8'h04;
	localparam logic [7:0] ADDR_HOLD = 8'h08;
	localparam logic [7:0] ADDR_MANUAL = 8'h0c;
	localparam logic [7:0] ADDR_STATUS = 8'h10;
	localparam logic [7:0] ADDR_EVENTS = 8'h14;
	localparam logic [7:0] ADDR_FAULTS = 8'h18;

	localparam int CTRL_AUTO_BIT = 0;
	localparam int CTRL_MASK_RX_BIT = 1;
	localparam int CTRL_MASK_TX_BIT = 2;
	localparam int HOLD_BACKUP_LSB = 0;
	localparam int HOLD_RESTORE_LSB = 8;
	localparam int MAN_SLOT_LSB = 0;
	localparam int MAN_CMD_LSB = 4;
	localparam int ST_SLOT_LSB = 0;
	localparam int ST_STATE_LSB = 4;
	localparam int ST_RED_BIT = 6;
	localparam int ST_AUTO_BIT = 7;
	localparam int FLT_RM_BIT = 16;

	localparam logic [1:0] MAN_RELEASE = 2'h0;
	localparam logic [1:0] MAN_BRIDGE = 2'h1;
	localparam logic [1:0] MAN_BACKUP = 2'h2;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic rx;
		logic tx;
	} mrf_fault_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_BRIDGE,
		ST_BACKUP
	} mrf_state_t;
endpackage : mrf_pkg

//--- design/mrf_failover.sv
// Failover controller for a one-for-ten modem redundancy switch
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// - Ten slots, active flags cleared at reset
// - Active flag only while interface card present
// - Poll every active modem, skip inactive slots
// - Status red until polled and configured
// - Reset into manual mode
// - Stored-event indicator blinks in manual mode
// - Manual: operator selects bridge, backup or release only
// - Auto: first failed modem bridged, then backed up
// - Bridge after backup holdoff, then switch over
// - Fault clearing early cancels pending backup
// - Redundant fault restores traffic once the modem has been clear for the restore holdoff
// - Holdoffs 1 to 99 seconds, default 10
// - Never switch to faulted redundant modem
// - Backed-up modem stays offline after clearing
// - New fault returns cleared modem, bridges new
// - Failures serviced as they expire; queued ones lowest slot first
// - Simultaneous faults: lower slot backed up
// - Bridge indicator lit for one modem only
// - Online indicators follow who carries traffic
// - Summary status follows modem fault states
// - Masked traffic-modem fault types ignored and not logged
module mrf_failover
	import mrf_pkg::*;
#(
	parameter int NUM_SLOTS = SLOTS,
	parameter int TICK_COUNT = TICK_CYCLES
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	input wire logic [NUM_SLOTS-1:0] modem_interface_card_i,
	input wire mrf_fault_t [NUM_SLOTS-1:0] tm_fault_i,
	input wire mrf_fault_t rm_fault_i,
	output logic poll_req_o,
	output logic [SLOT_W-1:0] poll_slot_o,
	input wire logic poll_ack_i,
	output logic rm_cfg_req_o,
	input wire logic rm_cfg_done_i,
	output logic [NUM_SLOTS-1:0] bridge_led_o,
	output logic [NUM_SLOTS-1:0] online_led_o,
	output logic rm_online_led_o,
	output logic switch_green_o,
	output logic stored_event_led_o
);
	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic auto_q, mask_rx_q, mask_tx_q, red_q, blink_q, ack_q;
	logic [NUM_SLOTS-1:0] active_q, pend_q, events_q, fault_q;
	logic [NUM_SLOTS-1:0] eff_fault, bk_cond, bk_exp, other_exp;
	logic [HOLD_W-1:0] bk_hold_q, rs_hold_q, conf_q, rs_q;
	logic [HOLD_W-1:0] bk_cnt_q [NUM_SLOTS];
	logic [SLOT_W-1:0] ptr_q, slot_q, first_slot;
	logic [31:0] tick_cnt_q, wmask, rdata, ctrl_nx, act_nx;
	logic tick, wr, rm_any, slot_fault, rs_done;
	mrf_state_t state_q;

	assign wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
	assign wr = cyc_i & stb_i & we_i & ack_q;
	assign ctrl_nx = dat_i & wmask;
	assign act_nx = (32'(active_q) & ~wmask) | (dat_i & wmask);

	function automatic logic hold_ok(input logic [HOLD_W-1:0] v);
		hold_ok = (v >= HOLD_MIN) && (v <= HOLD_MAX);
	endfunction : hold_ok

	// ----------------------------------------------------------------
	// One-second tick
	// ----------------------------------------------------------------
	assign tick = (tick_cnt_q == 32'(TICK_COUNT - 1));

	always_ff @(posedge clk_i) begin
		if (rst_i || tick) begin
			tick_cnt_q <= 32'h0000_0000;
		end else begin
			tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			blink_q <= 1'b0;
		end else if (tick) begin
			blink_q <= ~blink_q;
		end
	end

	// ----------------------------------------------------------------
	// Wishbone slave
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= cyc_i & stb_i & ~ack_q;
		end
	end
	assign ack_o = ack_q;

	always_comb begin
		rdata = 32'h0000_0000;
		unique case (adr_i)
			ADDR_CTRL: begin
				rdata[CTRL_AUTO_BIT] = auto_q;
				rdata[CTRL_MASK_RX_BIT] = mask_rx_q;
				rdata[CTRL_MASK_TX_BIT] = mask_tx_q;
			end
			ADDR_ACTIVE: rdata[NUM_SLOTS-1:0] = active_q;
			ADDR_HOLD: begin
				rdata[HOLD_BACKUP_LSB +: HOLD_W] = bk_hold_q;
				rdata[HOLD_RESTORE_LSB +: HOLD_W] = rs_hold_q;
			end
			ADDR_STATUS: begin
				rdata[ST_SLOT_LSB +: SLOT_W] = slot_q;
				rdata[ST_STATE_LSB +: 2] = state_q;
				rdata[ST_RED_BIT] = red_q;
				rdata[ST_AUTO_BIT] = auto_q;
			end
			ADDR_EVENTS: rdata[NUM_SLOTS-1:0] = events_q;
			ADDR_FAULTS: begin
				rdata[NUM_SLOTS-1:0] = fault_q;
				rdata[FLT_RM_BIT] = rm_any;
			end
			default: rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_o <= 32'h0000_0000;
		end else if (cyc_i && stb_i && !ack_q && !we_i) begin
			dat_o <= rdata;
		end
	end

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			auto_q <= 1'b0;
			mask_rx_q <= 1'b0;
			mask_tx_q <= 1'b0;
		end else if (wr && adr_i == ADDR_CTRL) begin
			auto_q <= ctrl_nx[CTRL_AUTO_BIT];
			mask_rx_q <= ctrl_nx[CTRL_MASK_RX_BIT];
			mask_tx_q <= ctrl_nx[CTRL_MASK_TX_BIT];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bk_hold_q <= HOLD_RST;
			rs_hold_q <= HOLD_RST;
		end else if (wr && adr_i == ADDR_HOLD) begin
			if (hold_ok(dat_i[HOLD_BACKUP_LSB +: HOLD_W]) && sel_i[0]) begin
				bk_hold_q <= dat_i[HOLD_BACKUP_LSB +: HOLD_W];
			end
			if (hold_ok(dat_i[HOLD_RESTORE_LSB +: HOLD_W]) && sel_i[1]) begin
				rs_hold_q <= dat_i[HOLD_RESTORE_LSB +: HOLD_W];
			end
		end
	end

	// ----------------------------------------------------------------
	// Active flags, polling and redundant configuration
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			active_q <= '0;
		end else if (wr && adr_i == ADDR_ACTIVE) begin
			active_q <= act_nx[NUM_SLOTS-1:0] & modem_interface_card_i;
		end else begin
			active_q <= active_q & modem_interface_card_i;
		end
	end

	assign poll_slot_o = ptr_q;
	assign poll_req_o = active_q[ptr_q];
	assign rm_cfg_req_o = red_q & ~|pend_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ptr_q <= '0;
		end else if (!active_q[ptr_q] || poll_ack_i) begin
			ptr_q <= (ptr_q == SLOT_W'(NUM_SLOTS - 1)) ? '0 : ptr_q + SLOT_W'(1);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pend_q <= '0;
			red_q <= 1'b1;
		end else if (wr && adr_i == ADDR_ACTIVE) begin
			pend_q <= act_nx[NUM_SLOTS-1:0] & modem_interface_card_i;
			red_q <= 1'b1;
		end else begin
			pend_q <= pend_q & active_q;
			if (poll_req_o && poll_ack_i) begin
				pend_q[ptr_q] <= 1'b0;
			end
			if (rm_cfg_req_o && rm_cfg_done_i) begin
				red_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Per-slot faults, events and backup holdoff counters
	// ----------------------------------------------------------------
	assign rm_any = rm_fault_i.rx | rm_fault_i.tx;

	for (genvar i = 0; i < NUM_SLOTS; i++) begin : g_slot
		logic rx_e, tx_e;
		assign rx_e = tm_fault_i[i].rx & ~mask_rx_q;
		assign tx_e = tm_fault_i[i].tx & ~mask_tx_q;
		assign eff_fault[i] = active_q[i] & (rx_e | tx_e);
		// Redundant modem must not show the same fault type
		assign bk_cond[i] = auto_q & active_q[i] &
			((rx_e & ~rm_fault_i.rx) | (tx_e & ~rm_fault_i.tx)) &
			~(state_q == ST_BACKUP && slot_q == SLOT_W'(i));
		assign bk_exp[i] = bk_cond[i] && bk_cnt_q[i] == '0;

		always_ff @(posedge clk_i) begin
			if (rst_i || !bk_cond[i]) begin
				bk_cnt_q[i] <= bk_hold_q;
			end else if (tick && bk_cnt_q[i] != '0) begin
				bk_cnt_q[i] <= bk_cnt_q[i] - HOLD_W'(1);
			end
		end

		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				fault_q[i] <= 1'b0;
			end else begin
				fault_q[i] <= eff_fault[i];
			end
		end

		// Sticky; a new fault edge wins over a write-one clear
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				events_q[i] <= 1'b0;
			end else if (eff_fault[i] && !fault_q[i]) begin
				events_q[i] <= 1'b1;
			end else if (wr && adr_i == ADDR_EVENTS && dat_i[i] && wmask[i]) begin
				events_q[i] <= 1'b0;
			end
		end
	end

	// Lowest of all expired slots wins, whatever the order in which they expired
	always_comb begin
		first_slot = '0;
		for (int j = NUM_SLOTS - 1; j >= 0; j--) begin
			if (other_exp[j]) begin
				first_slot = SLOT_W'(j);
			end
		end
	end

	assign other_exp = bk_exp & ~((state_q != ST_IDLE) ? (NUM_SLOTS'(1) << slot_q) : '0);

	// ----------------------------------------------------------------
	// Failover state machine
	// ----------------------------------------------------------------
	assign slot_fault = eff_fault[slot_q];
	assign rs_done = (rs_q == '0) && !slot_fault;

	always_ff @(posedge clk_i) begin
		if (rst_i || state_q != ST_BACKUP || slot_fault) begin
			rs_q <= rs_hold_q;
		end else if (tick && rs_q != '0) begin
			rs_q <= rs_q - HOLD_W'(1);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || state_q != ST_BRIDGE) begin
			conf_q <= bk_hold_q;
		end else if (tick && conf_q != '0) begin
			conf_q <= conf_q - HOLD_W'(1);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= ST_IDLE;
			slot_q <= '0;
		end else if (!auto_q) begin
			if (wr && adr_i == ADDR_MANUAL && sel_i[0]) begin
				unique case (dat_i[MAN_CMD_LSB +: 2])
					MAN_BRIDGE: if (active_q[dat_i[MAN_SLOT_LSB +: SLOT_W]]) begin
						state_q <= ST_BRIDGE;
						slot_q <= dat_i[MAN_SLOT_LSB +: SLOT_W];
					end
					MAN_BACKUP: if (active_q[dat_i[MAN_SLOT_LSB +: SLOT_W]] && !rm_any) begin
						state_q <= ST_BACKUP;
						slot_q <= dat_i[MAN_SLOT_LSB +: SLOT_W];
					end
					MAN_RELEASE: state_q <= ST_IDLE;
					default: state_q <= state_q;
				endcase
			end else if (!active_q[slot_q]) begin
				state_q <= ST_IDLE;
			end
		end else begin
			unique case (state_q)
				ST_IDLE: if (|other_exp) begin
					state_q <= ST_BRIDGE;
					slot_q <= first_slot;
				end
				ST_BRIDGE: if (!slot_fault || rm_any || !active_q[slot_q]) begin
					state_q <= ST_IDLE;
				end else if (conf_q == '0) begin
					state_q <= ST_BACKUP;
				end
				ST_BACKUP: if (!active_q[slot_q]) begin
					state_q <= ST_IDLE;
				end else if (rs_done && rm_any) begin
					state_q <= ST_IDLE;
				end else if (rs_done && |other_exp) begin
					state_q <= ST_BRIDGE;
					slot_q <= first_slot;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Indicators
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bridge_led_o <= '0;
			online_led_o <= '0;
			rm_online_led_o <= 1'b0;
			switch_green_o <= 1'b0;
			stored_event_led_o <= 1'b0;
		end else begin
			bridge_led_o <= '0;
			if (state_q != ST_IDLE) begin
				bridge_led_o[slot_q] <= 1'b1;
			end
			online_led_o <= active_q;
			if (state_q == ST_BACKUP) begin
				online_led_o[slot_q] <= 1'b0;
			end
			rm_online_led_o <= (state_q == ST_BACKUP);
			switch_green_o <= ~red_q & ~|eff_fault & ~rm_any;
			stored_event_led_o <= auto_q ? |events_q : blink_q;
		end
	end
endmodule : mrf_failover

`default_nettype wire

//--- bench/mrf_modems.sv
// Behavioural traffic and redundant modems answering polls and configuration
`timescale 1ns/1ns
`default_nettype none
module mrf_modems (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic slow_i,
	input wire logic poll_req_i,
	input wire logic rm_cfg_req_i,
	output logic poll_ack_o,
	output logic rm_cfg_done_o
);
	logic [3:0] wait_q;
	logic [3:0] lat;
	assign lat = slow_i ? 4'h6 : 4'h1;
	// One answer per request, after a prompt or slow delay
	always_ff @(posedge clk_i) begin
		poll_ack_o <= 1'b0;
		rm_cfg_done_o <= 1'b0;
		if (rst_i || !(poll_req_i || rm_cfg_req_i) || poll_ack_o || rm_cfg_done_o) begin
			wait_q <= 4'h0;
		end else if (wait_q == lat) begin
			poll_ack_o <= poll_req_i;
			rm_cfg_done_o <= rm_cfg_req_i;
			wait_q <= 4'h0;
		end else begin
			wait_q <= wait_q + 4'h1;
		end
	end
endmodule : mrf_modems
`default_nettype wire

//--- bench/mrf_failover_chk.sv
// Port assertions of the modem failover controller
`timescale 1ns/1ns
`default_nettype none
module mrf_failover_chk
	import mrf_pkg::*;
#(
	parameter int NUM_SLOTS = SLOTS
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic we_i,
	input wire logic [NUM_SLOTS-1:0] modem_interface_card_i,
	input wire mrf_fault_t rm_fault_i,
	input wire logic poll_req_o,
	input wire logic [SLOT_W-1:0] poll_slot_o,
	input wire logic poll_ack_i,
	input wire logic rm_cfg_req_o,
	input wire logic [NUM_SLOTS-1:0] bridge_led_o,
	input wire logic [NUM_SLOTS-1:0] online_led_o,
	input wire logic rm_online_led_o,
	input wire logic switch_green_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	a_bridge_one_hot: assert property ($onehot0(bridge_led_o))
		else $error("more than one bridge indicator lit");
	a_backup_recorded: assert property (rm_online_led_o |-> $onehot(bridge_led_o))
		else $error("backup without one recorded slot");
	a_backed_offline: assert property (rm_online_led_o |-> (bridge_led_o & online_led_o) == '0)
		else $error("backed-up slot still online");
	a_poll_advance: assert property (poll_req_o && poll_ack_i
		|=> poll_slot_o != $past(poll_slot_o))
		else $error("poll pointer stuck after answer");
	a_poll_wait: assert property (poll_req_o && !poll_ack_i
		&& $stable(modem_interface_card_i) && !(cyc_i && we_i) |=> $stable(poll_slot_o))
		else $error("poll pointer left an unanswered modem");
	a_red_not_green: assert property (rm_cfg_req_o |=> !switch_green_o)
		else $error("green while configuration pending");
	a_reset_clear: assert property ($fell(rst_i) |-> bridge_led_o == '0
		&& online_led_o == '0 && !rm_online_led_o)
		else $error("indicators lit after reset");
	a_no_faulted_rm: assert property ($rose(rm_online_led_o)
		|-> $past(rm_fault_i, 2) == 2'b00)
		else $error("switched onto faulted redundant modem");
	a_green_rm_fault: assert property (rm_fault_i != 2'b00
		&& $past(rm_fault_i) != 2'b00 |=> !switch_green_o)
		else $error("green with redundant modem faulted");
endmodule : mrf_failover_chk
`default_nettype wire

//--- bench/mrf_failover_tb_top.sv
// Self-checking testbench of the modem failover controller
`timescale 1ns/1ns
`default_nettype none
module mrf_failover_tb_top;
	import mrf_pkg::*;
	typedef struct packed {logic w; logic [7:0] a; logic [31:0] d;} mrf_row_t;
	localparam mrf_row_t ROWS [10] = '{'{0, ADDR_CTRL, 0}, '{0, ADDR_ACTIVE, 0},
		'{0, ADDR_HOLD, 32'h0000_0a0a}, '{1, ADDR_HOLD, 32'h0000_6301},
		'{0, ADDR_HOLD, 32'h0000_6301}, '{1, ADDR_HOLD, 32'h0000_6400},
		'{0, ADDR_HOLD, 32'h0000_6301}, '{1, ADDR_HOLD, 32'h0000_0202},
		'{0, ADDR_HOLD, 32'h0000_0202}, '{0, 8'hfc, 0}};
	logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, slow = 0, pa, cd, pr, cr, rmo, grn, sev;
	logic ack, b;
	logic [7:0] adr = 0;
	logic [31:0] wd = 0, rd, dq;
	logic [9:0] card = 10'h00f, brg, onl;
	logic [3:0] ps;
	mrf_fault_t [9:0] tf = '0;
	mrf_fault_t rf = '0;
	int n_mismatch = 0, compares = 0, i, k;
	always #50 clk_i = ~clk_i;
	mrf_failover #(.TICK_COUNT(20)) u_dut (.clk_i, .rst_i, .cyc_i(cyc), .stb_i(stb), .we_i(we),
		.adr_i(adr), .sel_i(4'hf), .dat_i(wd), .dat_o(rd), .ack_o(ack),
		.modem_interface_card_i(card), .tm_fault_i(tf), .rm_fault_i(rf), .poll_req_o(pr),
		.poll_slot_o(ps), .poll_ack_i(pa), .rm_cfg_req_o(cr), .rm_cfg_done_i(cd),
		.bridge_led_o(brg), .online_led_o(onl), .rm_online_led_o(rmo),
		.switch_green_o(grn), .stored_event_led_o(sev));
	mrf_modems u_modems (.clk_i, .rst_i, .slow_i(slow), .poll_req_i(pr), .rm_cfg_req_i(cr),
		.poll_ack_o(pa), .rm_cfg_done_o(cd));
	task automatic close_out;
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : close_out
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int j;
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		wd <= d;
		for (j = 0; j < 20 && ack !== 1'b1; j++) @(posedge clk_i);
		dq = rd;
		cyc <= 0;
		stb <= 0;
		if (j == 20) begin
			n_mismatch++;
			close_out();
		end
		@(posedge clk_i);
	endtask : wb
	task automatic wt(input logic [9:0] e, input logic r);
		int j;
		for (j = 0; j < 600 && {rmo, brg} !== {r, e}; j++) @(posedge clk_i);
		chk(32'({rmo, brg}), 32'({r, e}));
		if (j == 600) close_out();
	endtask : wt
	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 0;
		@(posedge clk_i);
		foreach (ROWS[n]) begin
			wb(ROWS[n].w, ROWS[n].a, ROWS[n].d);
			if (!ROWS[n].w) chk(dq, ROWS[n].d);
		end
		// Commit with slow modems
		slow <= 1;
		wb(1, ADDR_ACTIVE, 32'h0000_03ff);
		wb(0, ADDR_ACTIVE, 0);
		chk(dq, 32'h0000_000f);
		chk(32'(grn), 0);
		for (i = 0; i < 400 && grn !== 1'b1; i++) @(posedge clk_i);
		chk(32'(grn), 1);
		if (i == 400) close_out();
		chk(32'(onl), 32'h0000_000f);
		slow <= 0;
		// Manual commands
		wb(1, ADDR_MANUAL, 32'h0000_0012);
		wt(10'h004, 0);
		wb(1, ADDR_MANUAL, 32'h0000_0022);
		wt(10'h004, 1);
		chk(32'(onl), 32'h0000_000b);
		wb(1, ADDR_MANUAL, 32'h0000_0002);
		wt(10'h000, 0);
		tf[1] <= 2'b10;
		k = 0;
		repeat (100) begin
			b = sev;
			@(posedge clk_i);
			k += int'(sev !== b);
		end
		chk(32'(k > 3 && k < 6), 1);
		chk(32'({rmo, brg}), 0);
		// Automatic mode
		tf[1] <= '0;
		wb(1, ADDR_CTRL, 32'h0000_0001);
		wb(1, ADDR_EVENTS, 32'h0000_03ff);
		repeat (60) @(posedge clk_i);
		chk(32'(sev), 0);
		tf[1] <= 2'b01;
		repeat (15) @(posedge clk_i);
		tf[1] <= '0;
		repeat (80) @(posedge clk_i);
		chk(32'({rmo, brg}), 0);
		tf[1] <= 2'b10;
		wt(10'h002, 0);
		wt(10'h002, 1);
		chk(32'(onl), 32'h0000_000d);
		tf[1] <= '0;
		repeat (100) @(posedge clk_i);
		chk(32'({rmo, brg}), 32'h0000_0402);
		tf[3] <= 2'b01;
		wt(10'h008, 0);
		chk(32'(onl), 32'h0000_000f);
		wt(10'h008, 1);
		tf[3] <= '0;
		rf <= 2'b10;
		wt(10'h000, 0);
		chk(32'(onl), 32'h0000_000f);
		rf <= 2'b11;
		tf[0] <= 2'b01;
		tf[2] <= 2'b01;
		repeat (150) @(posedge clk_i);
		chk(32'({rmo, brg}), 0);
		rf <= '0;
		wt(10'h001, 0);
		wt(10'h001, 1);
		chk(32'(grn), 0);
		wb(0, ADDR_STATUS, 0);
		chk(dq, 32'h0000_00a0);
		wb(0, ADDR_EVENTS, 0);
		chk(dq, 32'h0000_000f);
		chk(32'(sev), 1);
		wb(1, ADDR_CTRL, 32'h0000_0005);
		wb(0, ADDR_FAULTS, 0);
		chk(dq, 0);
		chk(32'(grn), 1);
		close_out();
	end
endmodule : mrf_failover_tb_top
bind mrf_failover mrf_failover_chk #(.NUM_SLOTS(NUM_SLOTS)) u_chk (.clk_i, .rst_i, .cyc_i,
	.we_i, .modem_interface_card_i, .rm_fault_i, .poll_req_o, .poll_slot_o, .poll_ack_i,
	.rm_cfg_req_o, .bridge_led_o, .online_led_o, .rm_online_led_o, .switch_green_o);
`default_nettype wire
